/* timer_pkg.sv */
// constants and register map of the prescaled interval timer
`default_nettype none
package timer_pkg;
	localparam logic [4:0] ADDR_COUNT = 5'h00;
	localparam logic [4:0] ADDR_SCALE = 5'h04;
	localparam logic [4:0] ADDR_PERIOD = 5'h08;
	localparam logic [4:0] ADDR_CTRL = 5'h0C;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam logic [4:0] ADDR_MASK = 5'h14;
	localparam int CTRL_EN_BIT = 0;
	localparam int IRQ_ZERO_BIT = 0;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [7:0] SCALE_RESET = 8'h00;
	localparam logic [15:0] PERIOD_RESET = 16'h0000;
	localparam logic CTRL_EN_RESET = 1'b0;
	localparam logic MASK_RESET = 1'b0;
endpackage
`default_nettype wire

/* prescale_counter.sv */
// prescaler: one tick every scale+1 cycles
`default_nettype none
module prescale_counter #(
	parameter int W = 8
) (
	input wire logic mclk, // clock
	input wire logic rst_n, // sync reset, active low
	input wire logic run, // counting allowed
	input wire logic restart, // reload from scale now
	input wire logic [W-1:0] scale, // cycles per tick minus one
	output logic tick // one-cycle decrement pulse
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic tick;
	} pre_state_t;
	pre_state_t state_reg;
	pre_state_t state_next;

	// count down, reload on expiry and issue a pulse
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (restart || !run) begin
			state_next.cnt = scale;
		end else if (state_reg.cnt == '0) begin
			state_next.cnt = scale;
			state_next.tick = 1'b1;
		end else begin
			state_next.cnt = state_reg.cnt - 1'b1;
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
	assign tick = state_reg.tick;
endmodule
`default_nettype wire

/* prescaled_interval_timer.sv */
// interval timer with prescaler behind a classic wishbone slave
//
// Design decisions made here: the Wishbone slave port and the placing of the registers.
`default_nettype none
module prescaled_interval_timer
	import timer_pkg::*;
#(
	parameter int CW = 16,
	parameter int SW = 8
) (
	input wire logic mclk, // 100 MHz clock
	input wire logic rst_n, // sync reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write enable
	input wire logic [4:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // acknowledge
	output logic timer_irq // level interrupt request
);
	typedef struct packed {
		logic [CW-1:0] count;
		logic [SW-1:0] scale;
		logic [CW-1:0] period;
		logic enable;
		logic status;
		logic mask;
		logic irq;
		logic ack;
		logic [31:0] rdata;
	} tmr_state_t;
	tmr_state_t state_reg;
	tmr_state_t state_next;
	logic tick;
	logic req;
	logic wr;
	logic restart;

	assign req = wb_cyc_i && wb_stb_i && !state_reg.ack;
	assign wr = req && wb_we_i;
	// rewriting the scale restarts the prescale period
	assign restart = wr && (wb_adr_i == ADDR_SCALE) && wb_sel_i[0];

	// tick source for the count, fed the scale as it will stand
	// so that a restart loads the value just written
	prescale_counter #(
		.W(SW)
	) u_pre (
		.mclk(mclk),
		.rst_n(rst_n),
		.run(state_reg.enable),
		.restart(restart),
		.scale(state_next.scale),
		.tick(tick)
	);

	// counter, registers, bus answer and interrupt
	always_comb begin
		logic zero_evt;
		zero_evt = 1'b0;
		state_next = state_reg;
		state_next.ack = req;
		// count and reload
		if (state_reg.enable && tick) begin
			if (state_reg.count == '0) begin
				state_next.count = state_reg.period;
				zero_evt = 1'b1;
			end else begin
				state_next.count = state_reg.count - 1'b1;
			end
		end
		// register writes, software beats the counter on the count
		if (wr) begin
			case (wb_adr_i)
				ADDR_COUNT: begin
					if (wb_sel_i[0]) state_next.count[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) state_next.count[15:8] = wb_dat_i[15:8];
				end
				ADDR_SCALE: begin
					if (wb_sel_i[0]) state_next.scale = wb_dat_i[7:0];
				end
				ADDR_PERIOD: begin
					if (wb_sel_i[0]) state_next.period[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) state_next.period[15:8] = wb_dat_i[15:8];
				end
				ADDR_CTRL: begin
					if (wb_sel_i[0]) state_next.enable = wb_dat_i[CTRL_EN_BIT];
				end
				ADDR_STATUS: begin
					if (wb_sel_i[0] && wb_dat_i[IRQ_ZERO_BIT])
						state_next.status = 1'b0;
				end
				ADDR_MASK: begin
					if (wb_sel_i[0]) state_next.mask = wb_dat_i[IRQ_ZERO_BIT];
				end
				default: begin
				end
			endcase
		end
		// a new zero event wins over a clear in the same cycle
		if (zero_evt) state_next.status = 1'b1;
		state_next.irq = state_next.status && state_next.mask;
		// read data, unmapped addresses read zero
		state_next.rdata = 32'h0000_0000;
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ADDR_COUNT: state_next.rdata[15:0] = state_reg.count;
				ADDR_SCALE: state_next.rdata[7:0] = state_reg.scale;
				ADDR_PERIOD: state_next.rdata[15:0] = state_reg.period;
				ADDR_CTRL: state_next.rdata[0] = state_reg.enable;
				ADDR_STATUS: state_next.rdata[0] = state_reg.status;
				ADDR_MASK: state_next.rdata[0] = state_reg.mask;
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_reg <= '0;
			state_reg.count <= COUNT_RESET;
			state_reg.scale <= SCALE_RESET;
			state_reg.period <= PERIOD_RESET;
			state_reg.enable <= CTRL_EN_RESET;
			state_reg.mask <= MASK_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign wb_ack_o = state_reg.ack;
	assign wb_dat_o = state_reg.rdata;
	assign timer_irq = state_reg.irq;
endmodule
`default_nettype wire

/* timer_props.sv */
// bus and interrupt checks for the interval timer
`default_nettype none
module timer_props import timer_pkg::*; (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [4:0] wb_adr_i, // address
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire logic timer_irq // interrupt
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// handshake timing, idle read data and widths, interrupt fall only on a write ack
	AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack long");
	AST_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("data not idle");
	AST_SCALE: assert property (wb_ack_o && wb_adr_i == ADDR_SCALE
		|-> wb_dat_o[31:8] == 24'h0)
		else $error("scale wide");
	AST_CNT: assert property (wb_ack_o && (wb_adr_i == ADDR_COUNT ||
		wb_adr_i == ADDR_PERIOD) |-> wb_dat_o[31:16] == 16'h0)
		else $error("count wide");
	AST_FALL: assert property ($fell(timer_irq)
		|-> wb_ack_o && wb_we_i)
		else $error("irq fell alone");
endmodule
bind prescaled_interval_timer timer_props u_props (.*);
`default_nettype wire

/* irq_sink.sv */
// interrupt side model: cycles between request rises
`default_nettype none
module irq_sink (
	input wire logic mclk, // clock
	input wire logic irq, // request line
	output logic [15:0] gap // last rise to rise span
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] n = 16'h0;
	logic prev = 1'b0;
	// count cycles, latch the span at each rise
	always @(posedge mclk) begin
		prev <= irq;
		n <= (irq && !prev) ? 16'h1 : n + 16'h1;
		if (irq && !prev) gap <= n;
	end
endmodule
`default_nettype wire

/* tb.sv */
// register and timing tests for the interval timer
`default_nettype none
module tb import timer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, rst_n = 0, cyc = 0, we = 0, irq, ack;
	logic [4:0] adr = 0;
	logic [31:0] dw = 0, dr, q;
	logic [15:0] gap;
	logic [3:0] sel = 4'hF, lanes = 4'hF;
	int fail_count = 0, tests_run = 0;
	prescaled_interval_timer DUT (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .timer_irq(irq));
	irq_sink SINK (.mclk(mclk), .irq(irq), .gap(gap));
	initial forever #5 mclk = ~mclk;
	task automatic bus(input logic w, logic [4:0] a, logic [31:0] d);
		cyc <= 1'b1;
		sel <= lanes;
		we <= w;
		adr <= a;
		dw <= d;
		do @(posedge mclk); while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wirq;
		do @(posedge mclk); while (irq !== 1'b1);
	endtask
	task automatic chk(logic [31:0] g, e);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// watchdog
	initial begin
		#100000;
		fail_count++;
		conclude;
	end
	// main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			bus(0, 5'(i * 4), 0);
			chk(q, 0);
		end
		bus(1, ADDR_COUNT, 32'hFFFF1234);
		bus(0, ADDR_COUNT, 0);
		chk(q, 32'h1234);
		bus(1, ADDR_SCALE, 32'hFFFFFF03);
		bus(0, ADDR_SCALE, 0);
		chk(q, 32'h3);
		bus(1, ADDR_PERIOD, 32'hFFFF0002);
		bus(0, ADDR_PERIOD, 0);
		chk(q, 32'h2);
		bus(1, 5'h18, 32'h5);
		bus(0, 5'h18, 0);
		chk(q, 0);
		bus(1, ADDR_COUNT, 1);
		bus(1, ADDR_MASK, 1);
		bus(1, ADDR_CTRL, 1);
		repeat (2) begin
			wirq;
			bus(1, ADDR_STATUS, 1);
		end
		chk(gap, 12);
		bus(1, ADDR_MASK, 0);
		repeat (30) @(posedge mclk);
		chk(irq, 0);
		bus(0, ADDR_STATUS, 0);
		chk(q, 1);
		bus(1, ADDR_MASK, 1);
		@(posedge mclk);
		chk(irq, 1);
		// stopped count holds, upper lane alone, scale ignores lane 1
		bus(1, ADDR_CTRL, 0);
		bus(1, ADDR_COUNT, 32'h5678);
		lanes = 4'h2;
		bus(1, ADDR_COUNT, 32'hABCD);
		bus(1, ADDR_SCALE, 32'h7);
		lanes = 4'hF;
		repeat (20) @(posedge mclk);
		bus(0, ADDR_COUNT, 0);
		chk(q, 32'hAB78);
		bus(0, ADDR_SCALE, 0);
		chk(q, 32'h3);
		// scale rewritten while running sets a new interval
		bus(1, ADDR_COUNT, 0);
		bus(1, ADDR_STATUS, 1);
		bus(1, ADDR_CTRL, 1);
		bus(1, ADDR_SCALE, 1);
		repeat (2) begin
			wirq;
			bus(1, ADDR_STATUS, 1);
		end
		chk(gap, 6);
		conclude;
	end
endmodule
`default_nettype wire
